// >>> design/epi_pkg.sv
// package for the external pin interrupt pair
package epi_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PIN_SEL_W = 3;
	localparam logic [7:0] ADDR_TIMER_INTERRUPT_CONTROL_REG = 8'h88;
	localparam logic [7:0] ADDR_CFG_REG = 8'he4;
	localparam logic [7:0] ADDR_STAT_REG = 8'hf0;
	localparam logic [7:0] ADDR_MASK_REG = 8'hf1;
	localparam int unsigned BIT_EDGE_A = 0;
	localparam int unsigned BIT_PEND_A = 1;
	localparam int unsigned BIT_EDGE_B = 2;
	localparam int unsigned BIT_PEND_B = 3;
	localparam int unsigned CFG_SEL_A_LSB = 0;
	localparam int unsigned CFG_POL_A = 3;
	localparam int unsigned CFG_SEL_B_LSB = 4;
	localparam int unsigned CFG_POL_B = 7;
	localparam logic [7:0] TIMER_INTERRUPT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h01;
	localparam logic [1:0] STAT_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// pins idle high on their pull-ups
	localparam logic [7:0] SYNC_RESET = 8'hff;
	typedef struct packed {
		logic       edge_sel;
		logic       polarity;
		logic [2:0] pin_sel;
	} epi_src_cfg_s;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} epi_bus_req_s;
endpackage

// >>> design/epi_top.sv
// two external pin interrupt sources with register port
`timescale 1ns/1ns
`default_nettype none
module epi_top (
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	input  wire logic [7:0]                  port_pins_i,
	input  wire logic [epi_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [epi_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	input  wire logic [1:0]                  vector_ack_i,
	output logic      [epi_pkg::DATA_W-1:0]  rdata_o,
	output logic      [1:0]                  irq_pending_o,
	output logic                             irq_o
);
	epi_pkg::epi_bus_req_s req;
	epi_pkg::epi_src_cfg_s cfg [2];
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [1:0] sample_r;
	logic [1:0] active;
	logic [1:0] edge_seen;
	logic [1:0] edge_sel_r;
	logic [1:0] edge_pend_r;
	logic [1:0] pend;
	logic [7:0] cfg_r;
	logic [7:0] timer_interrupt_control_other_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic [1:0] pend_q_r;
	logic [7:0] rdata_nxt;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			// idle level, so no false edge or level after reset
			sync1_r <= epi_pkg::SYNC_RESET;
			sync2_r <= epi_pkg::SYNC_RESET;
		end else begin
			sync1_r <= port_pins_i;
			sync2_r <= sync1_r;
		end
	end

	assign cfg[0] = '{edge_sel: edge_sel_r[0],
		polarity: cfg_r[epi_pkg::CFG_POL_A],
		pin_sel: cfg_r[epi_pkg::CFG_SEL_A_LSB +: epi_pkg::PIN_SEL_W]};
	assign cfg[1] = '{edge_sel: edge_sel_r[1],
		polarity: cfg_r[epi_pkg::CFG_POL_B],
		pin_sel: cfg_r[epi_pkg::CFG_SEL_B_LSB +: epi_pkg::PIN_SEL_W]};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_src
			assign active[g] = cfg[g].polarity ?
				sync2_r[cfg[g].pin_sel] : ~sync2_r[cfg[g].pin_sel];
			assign edge_seen[g] = active[g] & ~sample_r[g];
			assign pend[g] = cfg[g].edge_sel ? edge_pend_r[g] : active[g];
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sample_r <= 2'h0;
		end else begin
			sample_r <= active;
		end
	end

	// edge set wins over vector clear
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			edge_pend_r <= 2'h0;
		end else begin
			edge_pend_r <= (edge_pend_r & ~vector_ack_i & edge_sel_r) |
				(edge_seen & edge_sel_r);
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cfg_r <= epi_pkg::CFG_RESET;
		end else if (req.wr && req.addr == epi_pkg::ADDR_CFG_REG) begin
			cfg_r <= req.wdata;
		end
	end

	// trigger select bits in control register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			edge_sel_r   <= 2'h0;
			timer_interrupt_control_other_r <= epi_pkg::TIMER_INTERRUPT_CONTROL_RESET;
		end else if (req.wr && req.addr == epi_pkg::ADDR_TIMER_INTERRUPT_CONTROL_REG) begin
			edge_sel_r[0] <= req.wdata[epi_pkg::BIT_EDGE_A];
			edge_sel_r[1] <= req.wdata[epi_pkg::BIT_EDGE_B];
			timer_interrupt_control_other_r  <= req.wdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			mask_r <= epi_pkg::MASK_RESET;
		end else if (req.wr && req.addr == epi_pkg::ADDR_MASK_REG) begin
			mask_r <= req.wdata[1:0];
		end
	end

	// sticky status on pending rise; set wins over clear
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pend_q_r <= 2'h0;
			stat_r   <= epi_pkg::STAT_RESET;
		end else begin
			pend_q_r <= pend;
			if (req.wr && req.addr == epi_pkg::ADDR_STAT_REG) begin
				stat_r <= (stat_r & ~req.wdata[1:0]) | (pend & ~pend_q_r);
			end else begin
				stat_r <= stat_r | (pend & ~pend_q_r);
			end
		end
	end

	// pending flags in control register bits
	always_comb begin
		rdata_nxt = 8'h00;
		if (req.addr == epi_pkg::ADDR_TIMER_INTERRUPT_CONTROL_REG) begin
			rdata_nxt = timer_interrupt_control_other_r & 8'hf0;
			rdata_nxt[epi_pkg::BIT_EDGE_A] = edge_sel_r[0];
			rdata_nxt[epi_pkg::BIT_PEND_A] = pend[0];
			rdata_nxt[epi_pkg::BIT_EDGE_B] = edge_sel_r[1];
			rdata_nxt[epi_pkg::BIT_PEND_B] = pend[1];
		end else if (req.addr == epi_pkg::ADDR_CFG_REG) begin
			rdata_nxt = cfg_r;
		end else if (req.addr == epi_pkg::ADDR_STAT_REG) begin
			rdata_nxt = {6'h00, stat_r};
		end else if (req.addr == epi_pkg::ADDR_MASK_REG) begin
			rdata_nxt = {6'h00, mask_r};
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (req.rd) begin
			rdata_o <= rdata_nxt;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			irq_pending_o <= 2'h0;
			irq_o         <= 1'b0;
		end else begin
			irq_pending_o <= pend;
			irq_o         <= |(stat_r & mask_r);
		end
	end
endmodule
`default_nettype wire

// >>> test/epi_props.sv
// property checker for the pin interrupt pair
`timescale 1ns/1ns
`default_nettype none
module epi_props (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] port_pins_i,
	input wire logic [7:0] addr_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [1:0] vector_ack_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] irq_pending_o,
	input wire logic       irq_o
);
	logic [2:0] q_r;
	logic [7:0] p_r;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// cycles since last stimulus
	always_ff @(posedge clock_i) begin
		p_r <= port_pins_i;
		if (!rst_n_i || wr_i || |vector_ack_i || port_pins_i != p_r)
			q_r <= 3'h0;
		else if (q_r != 3'h7)
			q_r <= q_r + 3'h1;
	end
	AST_QUIET_PEND: assert property (
		q_r == 3'h7 |-> $stable(irq_pending_o)) else $error("pending moved");
	AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	AST_PEND_A: assert property (
		$past(rd_i && addr_i == 8'h88) |-> rdata_o[1] == irq_pending_o[0])
		else $error("pending a bit wrong");
	AST_PEND_B: assert property (
		$past(rd_i && addr_i == 8'h88) |-> rdata_o[3] == irq_pending_o[1])
		else $error("pending b bit wrong");
	AST_RST_OUT: assert property ($rose(rst_n_i) |-> !irq_o && !rdata_o)
		else $error("outputs not clear after reset");
	AST_UNMAPPED_RD: assert property (
		$past(rd_i && addr_i == 8'h3c) |-> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	cover property ($rose(irq_o));
	cover property (|vector_ack_i);
	cover property ($fell(irq_pending_o[1]));
endmodule
`default_nettype wire

// >>> test/epi_pin_src.sv
// pin source model for the port pins
`timescale 1ns/1ns
`default_nettype none
module epi_pin_src (
	input  wire logic       clock_i,
	input  wire logic [7:0] level_i,
	output var  logic [7:0] pins_o
);
	initial pins_o = 8'hff;
	always @(posedge clock_i)
		pins_o <= level_i;
endmodule
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the pin interrupt pair
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic       rd_d = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, lvl = 8'hff, pins, rdata_o;
	logic [1:0] ack = 2'h0, pend;
	logic       irq_o;
	logic [7:0] exp_q[$];
	int         miscompares = 0, samples_checked = 0, cyc = 0;
	always #5 clock_i = ~clock_i;
	epi_pin_src PS (.clock_i(clock_i), .level_i(lvl), .pins_o(pins));
	epi_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .port_pins_i(pins),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.vector_ack_i(ack), .rdata_o(rdata_o), .irq_pending_o(pend),
		.irq_o(irq_o));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
		cmp(got, exp);
	endtask
	task automatic summarize();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		if (!w)
			exp_q.push_back(d);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
	endtask
	task automatic drv(input logic [7:0] v, input logic [1:0] a);
		@(posedge clock_i);
		lvl <= v;
		ack <= a;
		@(posedge clock_i);
		ack <= 2'h0;
		repeat (8) @(posedge clock_i);
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (rd_d)
			cmp(rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
		if (cyc == 2000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		void'($urandom(13182));
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		bus(0, 8'h88, 8'h00);
		bus(0, 8'he4, 8'h01);
		bus(0, 8'h3c, 8'h00);
		bus(1, 8'he4, 8'h58);
		repeat (5) begin
			drv(8'($urandom()), 2'h0);
			cmp_out({6'h0, pend}, {6'h0, ~lvl[5], lvl[0]});
			bus(0, 8'h88, {4'h0, ~lvl[5], 1'b0, lvl[0], 1'b0});
		end
		drv(8'hff, 2'h0);
		bus(1, 8'h88, 8'h05);
		bus(0, 8'h88, 8'h05);
		drv(8'h00, 2'h0);
		bus(0, 8'h88, 8'h0d);
		drv(8'hff, 2'h0);
		bus(0, 8'h88, 8'h0f);
		drv(8'hff, 2'h2);
		bus(0, 8'h88, 8'h07);
		drv(8'hff, 2'h1);
		bus(1, 8'hf0, 8'h03);
		bus(1, 8'hf1, 8'h01);
		bus(0, 8'hf0, 8'h00);
		drv(8'h00, 2'h0);
		drv(8'hff, 2'h0);
		cmp_out({7'h0, irq_o}, 8'h01);
		bus(1, 8'hf0, 8'h01);
		bus(0, 8'hf0, 8'h02);
		cmp_out({7'h0, irq_o}, 8'h00);
		repeat (3) @(posedge clock_i);
		summarize();
	end
endmodule
bind epi_top epi_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.port_pins_i(port_pins_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
	.vector_ack_i(vector_ack_i), .rdata_o(rdata_o),
	.irq_pending_o(irq_pending_o), .irq_o(irq_o));
`default_nettype wire
